// [include/pdx_pkg.sv]
// Package for the phase detector and exact frequency register bank.
// Assumes a single 40 MHz clock domain and a 32-bit classic Wishbone bus.
package pdx_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  // Printed offsets are register indices; byte address is index times four
  localparam logic [3:0]  PD_INDEX    = 4'hB;
  localparam logic [3:0]  EF_INDEX    = 4'hC;
  localparam int          REG_W       = 24;
  localparam logic [23:0] PD_RESET    = 24'h07C061;
  localparam logic [23:0] EF_RESET    = 24'h000000;

  // Smallest channel count that switches exact frequency mode on
  localparam logic [13:0] EXACT_MIN_RATIO = 14'h0002;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int          CLOCK_HZ    = 40000000;
  // Cycle slip thresholds in picoseconds, as nominal figures
  localparam logic [15:0] CSP_T1_PS   = 16'h1518;  // 5.4 ns
  localparam logic [15:0] CSP_T2_PS   = 16'h3840;  // 14.4 ns
  localparam logic [15:0] CSP_T3_PS   = 16'h5E24;  // 24.1 ns

  // ****************************************************************
  // Field layouts
  // ****************************************************************
  typedef struct packed {
    logic [4:0] upper_reserved;       // [23:19]
    logic [1:0] modulus_counter_clock_gating; // [18:17]
    logic [1:0] pump_amplifier_bias;  // [16:15]
    logic [2:0] mid_reserved;         // [14:12]
    logic       force_pump_mid_rail;  // [11]
    logic       force_pump_down;      // [10]
    logic       force_pump_up;        // [9]
    logic [1:0] cycle_slip_prevention_mode; // [8:7]
    logic       detector_down_output_enable; // [6]
    logic       detector_up_output_enable;   // [5]
    logic       detector_polarity_invert;    // [4]
    logic       detector_input_short;        // [3]
    logic [2:0] detector_reset_delay_select; // [2:0]
  } pdx_phase_cfg_t;

  typedef struct packed {
    logic [9:0]  reserved;            // [23:14]
    logic [13:0] channels_per_period; // [13:0]
  } pdx_exact_cfg_t;

endpackage

// [logic/pdx_exact_corrector.sv]
// Exact frequency correction sequencer.
// Assumes compare_tick is a one-cycle pulse per comparison period, same clock.
`timescale 1ns/1ps
`default_nettype none

module pdx_exact_corrector (
  input  wire logic        clock,             // 40 MHz clock
  input  wire logic        resetn,            // Async reset, active low
  input  wire logic        compare_tick,      // One pulse per comparison period
  input  wire logic [13:0] ratio,             // Channels per comparison period
  output logic             exact_enable,      // Exact frequency mode active
  output logic             correction_strobe  // Pulse once per ratio ticks
);

  typedef struct packed {
    logic [13:0] count;
    logic        strobe;
  } pdx_corr_state_t;

  pdx_corr_state_t s;
  pdx_corr_state_t next_s;

  // Ratios 0 and 1 leave the mode off
  assign exact_enable      = (ratio >= pdx_pkg::EXACT_MIN_RATIO);  // R11
  assign correction_strobe = s.strobe;

  // ****************************************************************
  // Period counter
  // ****************************************************************
  // Wraps every ratio ticks so on-grid channels get an exact correction
  always_comb begin
    next_s        = s;
    next_s.strobe = 1'b0;
    if (!exact_enable) begin
      next_s.count = 14'h0000;
    end else if (compare_tick) begin
      if (s.count >= ratio - 14'h0001) begin  // R12
        next_s.count  = 14'h0000;
        next_s.strobe = 1'b1;
      end else begin
        next_s.count = s.count + 14'h0001;
      end
    end
  end

  // State register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  a_strobe_at_wrap: assert property (exact_enable && compare_tick && s.count == ratio - 14'h0001 // R12
    |=> correction_strobe) else $error("strobe missing at period wrap");
  a_exact_off_quiet: assert property (!exact_enable |=> !correction_strobe) // R11
    else $error("strobe while exact mode off");

endmodule
`default_nettype wire

// [logic/pdx_regs.sv]
// Phase detector and exact frequency configuration bank with pump output gating.
// Assumes a classic Wishbone master on the same 40 MHz clock, and detector
// pulses and comparison ticks produced by logic on that clock.
// Forces are test aids: they override enables, short and mid-rail alike.
//
// Functional notes
// R01 - Reset-path delay field, resets to one
// R02 - Input-short test bit ties detector inputs
// R03 - Polarity bit swaps up and down sense
// R04 - Up enable gates up pulse, default on
// R05 - Down enable gates down pulse, default on
// R06 - Two-bit cycle slip threshold select
// R07 - Force-up holds pump up on
// R08 - Force-down holds pump down on
// R09 - Mid-rail test bit drives pump mid-rail
// R10 - Counter clock gating field, resets to three
// R11 - Ratio below two disables exact mode
// R12 - On-grid frequencies get zero frequency error
// R13 - Software keeps reserved and bias fields default
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
`default_nettype none

module pdx_regs #(
  parameter int ADDR_W = 8                    // Wishbone byte address width
) (
  input  wire logic              clock,             // 40 MHz clock
  input  wire logic              resetn,            // Async reset, active low
  input  wire logic              wb_cyc_i,          // Bus cycle
  input  wire logic              wb_stb_i,          // Strobe
  input  wire logic              wb_we_i,           // Write enable
  input  wire logic [ADDR_W-1:0] wb_adr_i,          // Byte address
  input  wire logic [3:0]        wb_sel_i,          // Byte lanes
  input  wire logic [31:0]       wb_dat_i,          // Write data
  output logic      [31:0]       wb_dat_o,          // Read data
  output logic                   wb_ack_o,          // Acknowledge
  input  wire logic              det_up_raw,        // Detector up pulse
  input  wire logic              det_down_raw,      // Detector down pulse
  input  wire logic              compare_tick,      // Comparison period tick
  output logic      [2:0]        reset_delay_select,// Detector reset delay
  output logic                   detector_input_short, // Inputs tied
  output logic      [1:0]        cycle_slip_prevention_mode, // Slip mode
  output logic                   csp_enable,        // Slip prevention on
  output logic      [15:0]       csp_threshold_ps,  // Slip threshold
  output logic      [1:0]        modulus_counter_clock_gating, // Gating
  output logic      [1:0]        pump_amplifier_bias, // Op-amp bias
  output logic                   pump_up,           // Pump up drive
  output logic                   pump_down,         // Pump down drive
  output logic                   pump_mid_rail,     // Pump mid-rail drive
  output logic                   exact_enable,      // Exact mode active
  output logic                   correction_strobe  // Exact correction pulse
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    pdx_pkg::pdx_phase_cfg_t pd;
    pdx_pkg::pdx_exact_cfg_t ef;
    logic                    ack;
    logic [31:0]             rdata;
    logic                    up;
    logic                    down;
  } pdx_regs_state_t;

  pdx_regs_state_t s;
  pdx_regs_state_t next_s;

  logic take;
  logic hit_pd;
  logic hit_ef;
  logic up_src;
  logic down_src;
  logic quiet;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Byte address of a register index
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [3:0] idx);
    byte_addr = ADDR_W'({idx, 2'b00});
  endfunction

  // Merge write data into a 24-bit register under byte lanes; lane 3 has no bits
  function automatic logic [23:0] apply_sel(input logic [23:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0]  sel);
    logic [23:0] r;
    r = old;
    for (int i = 0; i < 3; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    apply_sel = r;
  endfunction

  // Nominal threshold of each slip prevention setting
  function automatic logic [15:0] csp_ps(input logic [1:0] mode);
    unique case (mode)
      2'h0: csp_ps = 16'h0000;
      2'h1: csp_ps = pdx_pkg::CSP_T1_PS;
      2'h2: csp_ps = pdx_pkg::CSP_T2_PS;
      2'h3: csp_ps = pdx_pkg::CSP_T3_PS;
    endcase
  endfunction

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  // Exact address match, so misaligned or unmapped addresses read zero
  // Ack blocks a second take while the master still holds its request
  assign take   = wb_cyc_i && wb_stb_i && !s.ack;
  assign hit_pd = (wb_adr_i == byte_addr(pdx_pkg::PD_INDEX));
  assign hit_ef = (wb_adr_i == byte_addr(pdx_pkg::EF_INDEX));

  // ****************************************************************
  // Detector path
  // ****************************************************************
  // Polarity inversion swaps which detector pulse drives which pump side
  assign up_src   = s.pd.detector_polarity_invert ? det_down_raw : det_up_raw;   // R03
  assign down_src = s.pd.detector_polarity_invert ? det_up_raw   : det_down_raw; // R03
  // Tied inputs or a parked pump leave no real phase error to pass on
  assign quiet    = s.pd.detector_input_short || s.pd.force_pump_mid_rail;      // R02

  // Next state: register writes, read capture and pump drive
  always_comb begin
    next_s     = s;
    next_s.ack = take;
    if (take && wb_we_i) begin
      if (hit_pd) begin
        next_s.pd = pdx_pkg::pdx_phase_cfg_t'(apply_sel(s.pd, wb_dat_i, wb_sel_i)); // R01
      end
      if (hit_ef) begin
        next_s.ef = pdx_pkg::pdx_exact_cfg_t'(apply_sel(s.ef, wb_dat_i, wb_sel_i)); // R11
      end
    end
    if (take && !wb_we_i) begin
      if (hit_pd) begin
        next_s.rdata = {8'h00, s.pd};
      end else if (hit_ef) begin
        next_s.rdata = {8'h00, s.ef};
      end else begin
        next_s.rdata = 32'h0000_0000;
      end
    end
    // Forces win over gating so a stuck pump is visible on the bench
    next_s.up   = s.pd.force_pump_up ||                                        // R07
                  (s.pd.detector_up_output_enable && !quiet && up_src);        // R04
    next_s.down = s.pd.force_pump_down ||                                      // R08
                  (s.pd.detector_down_output_enable && !quiet && down_src);    // R05
  end

  // State register; reset loads documented defaults
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s.pd    <= pdx_pkg::pdx_phase_cfg_t'(pdx_pkg::PD_RESET); // R01
      s.ef    <= pdx_pkg::pdx_exact_cfg_t'(pdx_pkg::EF_RESET);
      s.ack   <= 1'b0;
      s.rdata <= 32'h0000_0000;
      s.up    <= 1'b0;
      s.down  <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Bus answer, pump drive and configuration fields from the register; slip enable and threshold decoded
  assign wb_dat_o                     = s.rdata;
  assign wb_ack_o                     = s.ack;
  assign reset_delay_select           = s.pd.detector_reset_delay_select;  // R01
  assign detector_input_short         = s.pd.detector_input_short;         // R02
  assign cycle_slip_prevention_mode   = s.pd.cycle_slip_prevention_mode;   // R06
  assign csp_enable                   = (s.pd.cycle_slip_prevention_mode != 2'h0); // R06
  assign csp_threshold_ps             = csp_ps(s.pd.cycle_slip_prevention_mode);   // R06
  assign modulus_counter_clock_gating = s.pd.modulus_counter_clock_gating; // R10
  assign pump_amplifier_bias          = s.pd.pump_amplifier_bias;
  assign pump_up                      = s.up;
  assign pump_down                    = s.down;
  assign pump_mid_rail                = s.pd.force_pump_mid_rail;          // R09

  // Exact frequency sequencer
  pdx_exact_corrector u_corrector (
    .clock             (clock),
    .resetn            (resetn),
    .compare_tick      (compare_tick),
    .ratio             (s.ef.channels_per_period),
    .exact_enable      (exact_enable),
    .correction_strobe (correction_strobe)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  // Field, gating and force behaviour against the register
  a_delay_write: assert property (take && wb_we_i && hit_pd && wb_sel_i[0] // R01
    |=> reset_delay_select == $past(wb_dat_i[2:0])) else $error("delay field not written");
  a_short_blocks: assert property (detector_input_short && !s.pd.force_pump_up // R02
    |=> !pump_up) else $error("pump up passes with inputs tied");
  a_polarity_swap: assert property (s.pd.detector_polarity_invert && s.pd.detector_up_output_enable // R03
    && !quiet && det_down_raw |=> pump_up) else $error("inverted down pulse not on up");
  a_up_gate: assert property (!s.pd.detector_up_output_enable && !s.pd.force_pump_up // R04
    |=> !pump_up) else $error("up pulse passes while disabled");
  a_down_gate: assert property (!s.pd.detector_down_output_enable && !s.pd.force_pump_down // R05
    |=> !pump_down) else $error("down pulse passes while disabled");
  a_csp_decode: assert property (cycle_slip_prevention_mode == 2'h2 // R06
    |-> csp_enable && csp_threshold_ps == pdx_pkg::CSP_T2_PS) else $error("slip threshold wrong");
  a_force_up: assert property (s.pd.force_pump_up [*2] |-> pump_up) // R07
    else $error("forced up not held");
  a_force_down: assert property (s.pd.force_pump_down [*2] |-> pump_down) // R08
    else $error("forced down not held");
  a_mid_rail: assert property (pump_mid_rail && !s.pd.force_pump_up && !s.pd.force_pump_down // R09
    |=> !pump_up && !pump_down) else $error("pump active at mid-rail");
  a_gating_write: assert property (take && wb_we_i && hit_pd && wb_sel_i[2] // R10
    |=> modulus_counter_clock_gating == $past(wb_dat_i[18:17])) else $error("gating not written");
  a_exact_enable: assert property (exact_enable == (s.ef.channels_per_period > 14'h0001)) // R11
    else $error("exact enable mismatch");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");

  // ****************************************************************
  // Bus answer checks
  // ****************************************************************
  // One ack per taken request, none without one
  a_ack_follows: assert property (take |=> wb_ack_o) else $error("request not acked");
  a_ack_needs_take: assert property (!take |=> !wb_ack_o) else $error("ack without request");
  // Read data is the register as it stood at the taking edge
  a_read_pd: assert property (take && !wb_we_i && hit_pd // R01
    |=> wb_dat_o == {8'h00, $past(s.pd)}) else $error("phase config read wrong");
  a_read_ef: assert property (take && !wb_we_i && hit_ef // R11
    |=> wb_dat_o == {8'h00, $past(s.ef)}) else $error("exact config read wrong");
  a_read_unmapped: assert property (take && !wb_we_i && !hit_pd && !hit_ef
    |=> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
  a_dat_holds: assert property (!(take && !wb_we_i) |=> $stable(wb_dat_o))
    else $error("read data moved without a read");
  // Only a write that hits a register may change the bank
  a_bank_holds: assert property (!(take && wb_we_i && (hit_pd || hit_ef))
    |=> $stable(s.pd) && $stable(s.ef)) else $error("bank changed without a write");

  // ****************************************************************
  // Field write checks
  // ****************************************************************
  // Each field follows its byte lane, or both lanes where it spans two, at the taking edge
  a_short_write: assert property (take && wb_we_i && hit_pd && wb_sel_i[0] // R02
    |=> detector_input_short == $past(wb_dat_i[3])) else $error("short bit not written");
  a_invert_write: assert property (take && wb_we_i && hit_pd && wb_sel_i[0] // R03
    |=> s.pd.detector_polarity_invert == $past(wb_dat_i[4])) else $error("polarity bit not written");
  a_up_en_write: assert property (take && wb_we_i && hit_pd && wb_sel_i[0] // R04
    |=> s.pd.detector_up_output_enable == $past(wb_dat_i[5])) else $error("up enable not written");
  a_down_en_write: assert property (take && wb_we_i && hit_pd && wb_sel_i[0] // R05
    |=> s.pd.detector_down_output_enable == $past(wb_dat_i[6])) else $error("down enable not written");
  a_csp_write: assert property (take && wb_we_i && hit_pd && wb_sel_i[0] && wb_sel_i[1] // R06
    |=> cycle_slip_prevention_mode == $past(wb_dat_i[8:7])) else $error("slip mode not written");
  a_force_write: assert property (take && wb_we_i && hit_pd && wb_sel_i[1] // R07
    |=> s.pd.force_pump_up == $past(wb_dat_i[9]) && s.pd.force_pump_down == $past(wb_dat_i[10]))
    else $error("force bits not written");
  a_mid_rail_write: assert property (take && wb_we_i && hit_pd && wb_sel_i[1] // R09
    |=> pump_mid_rail == $past(wb_dat_i[11])) else $error("mid-rail bit not written");
  a_ratio_write: assert property (take && wb_we_i && hit_ef && wb_sel_i[0] && wb_sel_i[1] // R11
    |=> s.ef.channels_per_period == $past(wb_dat_i[13:0])) else $error("ratio not written");
  a_enable_write: assert property (take && wb_we_i && hit_ef && wb_sel_i[0] && wb_sel_i[1] // R11
    |=> exact_enable == ($past(wb_dat_i[13:0]) >= pdx_pkg::EXACT_MIN_RATIO))
    else $error("exact enable not following ratio");

  // ****************************************************************
  // Detector and exact mode checks
  // ****************************************************************
  // Straight and swapped paths each carry their pulse one cycle later
  a_up_direct: assert property (!s.pd.detector_polarity_invert && s.pd.detector_up_output_enable // R04
    && !quiet && det_up_raw |=> pump_up) else $error("up pulse lost");
  a_down_direct: assert property (!s.pd.detector_polarity_invert && s.pd.detector_down_output_enable // R05
    && !quiet && det_down_raw |=> pump_down) else $error("down pulse lost");
  a_down_swap: assert property (s.pd.detector_polarity_invert && s.pd.detector_down_output_enable // R03
    && !quiet && det_up_raw |=> pump_down) else $error("inverted up pulse not on down");
  a_short_down: assert property (detector_input_short && !s.pd.force_pump_down // R02
    |=> !pump_down) else $error("pump down passes with inputs tied");
  // Without a pulse or a force the pump stays off
  a_up_idle: assert property (!s.pd.force_pump_up && !det_up_raw && !det_down_raw // R04
    |=> !pump_up) else $error("pump up without a pulse");
  a_down_idle: assert property (!s.pd.force_pump_down && !det_up_raw && !det_down_raw // R05
    |=> !pump_down) else $error("pump down without a pulse");
  a_csp_off: assert property (cycle_slip_prevention_mode == 2'h0 // R06
    |-> !csp_enable && csp_threshold_ps == 16'h0000) else $error("slip prevention not off");
  a_csp_low: assert property (cycle_slip_prevention_mode == 2'h1 // R06
    |-> csp_enable && csp_threshold_ps == pdx_pkg::CSP_T1_PS) else $error("low slip threshold wrong");
  a_csp_high: assert property (cycle_slip_prevention_mode == 2'h3 // R06
    |-> csp_enable && csp_threshold_ps == pdx_pkg::CSP_T3_PS) else $error("high slip threshold wrong");
  // A correction only ever follows a tick taken in exact mode
  a_strobe_source: assert property (correction_strobe |-> $past(compare_tick) && $past(exact_enable)) // R12
    else $error("strobe without a tick");

  c_pd_write:  cover property (take && wb_we_i && hit_pd);
  c_ef_read:   cover property (take && !wb_we_i && hit_ef);
  c_force_up:  cover property (s.pd.force_pump_up ##1 pump_up);
  c_strobe:    cover property (correction_strobe);
  c_swapped:   cover property (s.pd.detector_polarity_invert && det_up_raw ##1 pump_down);

endmodule
`default_nettype wire

// [verif/test_pdx_regs.sv]
// Self-checking bench for the phase detector and exact frequency register bank.
// Assumes pdx_regs with a classic Wishbone slave that acks one cycle after taking a request.
`timescale 1ns/1ps
`default_nettype none

module test_pdx_regs;
  logic        clock, resetn, wb_cyc_i, wb_stb_i, wb_we_i, det_up_raw, det_down_raw, compare_tick;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic        wb_ack_o, detector_input_short, csp_enable, pump_up, pump_down, pump_mid_rail;
  logic        exact_enable, correction_strobe;
  logic [2:0]  reset_delay_select;
  logic [1:0]  cycle_slip_prevention_mode, modulus_counter_clock_gating, pump_amplifier_bias;
  logic [15:0] csp_threshold_ps;
  int          failures, compares;
  // Nominal slip thresholds in picoseconds for modes 0 to 3
  logic [15:0] thr [4] = '{16'h0000, 16'h1518, 16'h3840, 16'h5E24};

  pdx_regs #(.ADDR_W(8)) u_pdx_regs (
    .clock(clock), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .det_up_raw(det_up_raw), .det_down_raw(det_down_raw),
    .compare_tick(compare_tick), .reset_delay_select(reset_delay_select),
    .detector_input_short(detector_input_short), .cycle_slip_prevention_mode(cycle_slip_prevention_mode),
    .csp_enable(csp_enable), .csp_threshold_ps(csp_threshold_ps),
    .modulus_counter_clock_gating(modulus_counter_clock_gating), .pump_amplifier_bias(pump_amplifier_bias),
    .pump_up(pump_up), .pump_down(pump_down), .pump_mid_rail(pump_mid_rail),
    .exact_enable(exact_enable), .correction_strobe(correction_strobe));

  // ****************************************************************
  // Clock, verdict and comparison
  // ****************************************************************
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic close_out();
    if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One classic cycle; holds everything until ack is sampled, then idles a cycle
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
      close_out();
    end
    @(posedge clock);
  endtask

  // Pump drive expected from config and raw pulses; forces win over any blocking
  function automatic logic [1:0] exp_pump(input logic [23:0] c, input logic u, input logic d);
    logic blk, pu, pdn;
    blk = c[3] | c[11];
    pu  = (c[4] ? d : u) & c[5] & ~blk;
    pdn = (c[4] ? u : d) & c[6] & ~blk;
    exp_pump = {c[10] | pdn, c[9] | pu};
  endfunction

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [31:0] q, data, rnd;
    logic [23:0] pd_shadow;
    logic [3:0]  sel;
    int          r, rl [6];
    rl = '{0, 1, 2, 3, 16383, 5};
    failures = 0;
    compares = 0;
    q = $urandom(32'h5F635D67);
    {resetn, wb_cyc_i, wb_stb_i, wb_we_i, det_up_raw, det_down_raw, compare_tick} = 7'h00;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    // Outputs at rest straight after reset
    chk(32'({wb_ack_o, pump_up, pump_down, correction_strobe, exact_enable, csp_enable}), 32'h0);
    chk(32'({reset_delay_select, modulus_counter_clock_gating, pump_mid_rail}), 32'h0000000E);
    bus(1'b0, 8'h2C, 32'h0, 4'hF, q);
    chk(q, 32'h0007C061);
    bus(1'b0, 8'h30, 32'h0, 4'hF, q);
    chk(q, 32'h00000000);
    pd_shadow = 24'h07C061;
    // Random configs with random lanes; reserved and bias bits kept at reset
    for (int i = 0; i < 48; i++) begin
      rnd  = $urandom;
      data = {rnd[31:24], (rnd[23:0] & 24'h060FFF) | (24'h07C061 & 24'hF9F000)};
      sel  = (i == 0) ? 4'hF : 4'($urandom);
      for (int k = 0; k < 3; k++) if (sel[k]) pd_shadow[8*k +: 8] = data[8*k +: 8];
      bus(1'b1, 8'h2C, data, sel, q);
      bus(1'b0, 8'h2C, 32'h0, 4'hF, q);
      chk(q, {8'h00, pd_shadow});
      chk(32'({reset_delay_select, detector_input_short, cycle_slip_prevention_mode, csp_enable,
               modulus_counter_clock_gating, pump_amplifier_bias, pump_mid_rail}),
          32'({pd_shadow[2:0], pd_shadow[3], pd_shadow[8:7], |pd_shadow[8:7],
               pd_shadow[18:17], pd_shadow[16:15], pd_shadow[11]}));
      chk(32'(csp_threshold_ps), 32'(thr[pd_shadow[8:7]]));
      for (int j = 0; j < 4; j++) begin
        det_up_raw   <= j[0];
        det_down_raw <= j[1];
        @(posedge clock);
        #1 chk(32'({pump_down, pump_up}), 32'(exp_pump(pd_shadow, j[0], j[1])));
        @(posedge clock);
      end
      det_up_raw   <= 1'b0;
      det_down_raw <= 1'b0;
    end
    // Unmapped and misaligned places read zero and leave the bank alone
    bus(1'b1, 8'h34, 32'hFFFFFFFF, 4'hF, q);
    bus(1'b0, 8'h34, 32'h0, 4'hF, q);
    chk(q, 32'h0);
    bus(1'b0, 8'h2D, 32'h0, 4'hF, q);
    chk(q, 32'h0);
    bus(1'b0, 8'h2C, 32'h0, 4'hF, q);
    chk(q, {8'h00, pd_shadow});
    // Exact frequency ratios, boundaries and one random value
    rl[5] = 2 + $urandom_range(0, 12);
    for (int i = 0; i < 6; i++) begin
      r = rl[i];
      bus(1'b1, 8'h30, 32'h0, 4'hF, q);
      bus(1'b1, 8'h30, 32'(r), 4'hF, q);
      bus(1'b0, 8'h30, 32'h0, 4'hF, q);
      chk(q, 32'(r));
      chk(32'(exact_enable), 32'(r >= 2));
      if (r <= 20) begin
        for (int k = 1; k <= 2 * r + 4; k++) begin
          compare_tick <= 1'b1;
          @(posedge clock);
          compare_tick <= 1'b0;
          #1 chk(32'(correction_strobe), 32'((r >= 2) && (k % r == 0)));
          @(posedge clock);
        end
      end
    end
    close_out();
  end
endmodule

`default_nettype wire
